// >>> src/crs_defs.vh
// Purpose: Constants for the conversion rate scheduler.
// Assumes: 200 MHz system clock.
// Notes:   Times are in microseconds; cycle counts derive from them.
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH
`define CRS_ADDR_RATE      8'h20
`define CRS_RATE_RESET     2'h2
`define CRS_RATE_LSB       0
`define CRS_RATE_MSB       1
`define CRS_CLK_MHZ        200
`define CRS_TEMP_CONV_US   7500
`define CRS_VOLT_CONV_US   1420
`define CRS_INTERVAL_US    91000
`define CRS_TEMP_CYCLES    (`CRS_TEMP_CONV_US * `CRS_CLK_MHZ)
`define CRS_VOLT_CYCLES    (`CRS_VOLT_CONV_US * `CRS_CLK_MHZ)
`define CRS_UNIT_CYCLES    (`CRS_INTERVAL_US * `CRS_CLK_MHZ)
`define CRS_TEMP_CHANNELS  3
`define CRS_VOLT_CHANNELS  5
`endif

// >>> src/crs_interval_timer.v
// Purpose: Counts scan interval time in units of the base interval.
// Assumes: Single clock domain.
// Notes:   Restarts on start; reports done once the selected multiple elapses.
`timescale 1ns/1ps
module crs_interval_timer
#(
  parameter UNIT_CYCLES = 18200000
)
(
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        resetn,
  // Control.
  input  wire        start,
  input  wire [4:0]  multiple,
  // Status.
  output reg         done
);
  reg [31:0] unitCount;
  reg [4:0]  units;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      unitCount <= 32'h0;
      units     <= 5'h0;
      done      <= 1'b0;
    end
    else if (start)
    begin
      unitCount <= 32'h0;
      units     <= 5'h0;
      done      <= 1'b0;
    end
    else if (!done)
    begin
      if (unitCount == UNIT_CYCLES - 1)
      begin
        unitCount <= 32'h0;
        units     <= units + 5'h1;
        if (units + 5'h1 >= multiple)
          done <= 1'b1;
      end
      else
        unitCount <= unitCount + 32'h1;
    end
  end
endmodule // crs_interval_timer

// >>> src/crs_scheduler.v
// Purpose: Scan rate register and round-robin conversion scheduler.
// Assumes: Register port is a decoded single-cycle access from the bus logic.
// Notes:   Interval is measured from the start of each scan.
`timescale 1ns/1ps
`include "crs_defs.vh"
module crs_scheduler
#(
  parameter TEMP_CYCLES = `CRS_TEMP_CYCLES,
  parameter VOLT_CYCLES = `CRS_VOLT_CYCLES,
  parameter UNIT_CYCLES = `CRS_UNIT_CYCLES
)
(
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        resetn,
  // Register access.
  input  wire [7:0]  regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata,
  // Other control register bits.
  input  wire        low_power_select,
  input  wire        attentionEnable,
  input  wire [4:0]  voltageSensorEnable,
  // Conversion status.
  output reg         convActive,
  output reg         convTemp,
  output reg  [2:0]  convChannel,
  output reg         scanStart,
  output reg         scanDone,
  output wire        attentionRequest,
  // Rate field view.
  output wire [1:0]  rateSelect
);
  // ****************************************************************
  // Register.
  // ****************************************************************
  // Scan sequencer states.
  localparam ST_IDLE = 2'h0;
  localparam ST_TEMP = 2'h1;
  localparam ST_VOLT = 2'h2;
  localparam ST_WAIT = 2'h3;

  reg [1:0]  scanRate;
  reg [1:0]  state;
  reg [31:0] convCount;
  reg        timerStart;
  wire       timerDone;

  assign rateSelect = scanRate;

  // True when the decoded access targets the scan rate register.
  function isRateAddr;
    input [7:0] addr;
    begin
      isRateAddr = (addr == `CRS_ADDR_RATE);
    end
  endfunction

  // Only the rate field is stored; the reserved bits cost no flops.
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      scanRate <= `CRS_RATE_RESET;
    else if (regWrite && isRateAddr(regAddr))
      scanRate <= regWdata[`CRS_RATE_MSB:`CRS_RATE_LSB];
  end

  // Reads of other addresses return zero rather than stale data.
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      regRdata <= 8'h0;
    else if (regRead)
    begin
      if (isRateAddr(regAddr))
        regRdata <= {6'h0, scanRate};
      else
        regRdata <= 8'h0;
    end
  end

  // ****************************************************************
  // Interval selection.
  // ****************************************************************
  // Returns the interval in base units; zero means continuous.
  function [4:0] intervalUnits;
    input [1:0] sel;
    input       lowPower;
    begin
      case ({lowPower, sel})
        3'h0:    intervalUnits = 5'h0;
        3'h1:    intervalUnits = 5'h1;
        3'h2:    intervalUnits = 5'h2;
        3'h3:    intervalUnits = 5'h4;
        3'h4:    intervalUnits = 5'h1;
        3'h5:    intervalUnits = 5'h4;
        3'h6:    intervalUnits = 5'h8;
        default: intervalUnits = 5'h10;
      endcase
    end
  endfunction

  // Continuous mode has no wait: the sequencer loops straight back to idle.
  wire [4:0] multiple = intervalUnits(scanRate, low_power_select);

  crs_interval_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) uTimer (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .start    (timerStart),
    .multiple (multiple),
    .done     (timerDone)
  );

  // ****************************************************************
  // Scan sequencer.
  // ****************************************************************
  // True on the last cycle of a conversion of the given length.
  function convEnd;
    input [31:0] count;
    input [31:0] length;
    begin
      convEnd = (count == length - 32'h1);
    end
  endfunction

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state       <= ST_IDLE;
      convCount   <= 32'h0;
      convChannel <= 3'h0;
      convActive  <= 1'b0;
      convTemp    <= 1'b0;
      scanStart   <= 1'b0;
      scanDone    <= 1'b0;
      timerStart  <= 1'b0;
    end
    else
    begin
      scanStart  <= 1'b0;
      scanDone   <= 1'b0;
      timerStart <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          state       <= ST_TEMP;
          convCount   <= 32'h0;
          convChannel <= 3'h0;
          convActive  <= 1'b1;
          convTemp    <= 1'b1;
          scanStart   <= 1'b1;
          // The timer restarts with the scan so the interval counts from scan start.
          timerStart  <= 1'b1;
        end
        ST_TEMP:
        begin
          if (convEnd(convCount, TEMP_CYCLES))
          begin
            convCount <= 32'h0;
            if (convChannel == `CRS_TEMP_CHANNELS - 1)
            begin
              state       <= ST_VOLT;
              convChannel <= 3'h0;
              convTemp    <= 1'b0;
            end
            else
              convChannel <= convChannel + 3'h1;
          end
          else
            convCount <= convCount + 32'h1;
        end
        ST_VOLT:
        begin
          if (convEnd(convCount, VOLT_CYCLES))
          begin
            convCount <= 32'h0;
            if (convChannel == `CRS_VOLT_CHANNELS - 1)
            begin
              state       <= ST_WAIT;
              convChannel <= 3'h0;
              convActive  <= 1'b0;
              scanDone    <= 1'b1;
            end
            else
              convChannel <= convChannel + 3'h1;
          end
          else
            convCount <= convCount + 32'h1;
        end
        ST_WAIT:
        begin
          // The multiple is read live, so a rate change reshapes the current wait.
          if (multiple == 5'h0 || timerDone)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Attention request.
  // ****************************************************************
  // One request per completed scan with attentionEnable and any voltage sensor enabled keeps the master in step with the scan rate.
  assign attentionRequest = scanDone && attentionEnable && (|voltageSensorEnable);
endmodule // crs_scheduler

// >>> sim/crs_host_model.sv
// Purpose: Host master model for the rate register. Assumes: one clock. Notes: released data is inverted.
`timescale 1ns/1ps
module crs_host_model (
  input  wire       clk_sys,
  input  wire [7:0] regRdata,
  output reg  [7:0] regAddr  = 8'h00,
  output reg        regWrite = 1'b0,
  output reg        regRead  = 1'b0,
  output reg  [7:0] regWdata = 8'h00
);
  task access(input w, input [7:0] a, input [7:0] dat);
    @(posedge clk_sys);
    regAddr  <= a;
    regWrite <= w;
    regRead  <= !w;
    regWdata <= dat;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    regWdata <= ~dat;
  endtask
  task wr(input [7:0] a, input [7:0] dat);
    access(1'b1, a, dat);
  endtask
  task rd(input [7:0] a, output [7:0] dat);
    access(1'b0, a, 8'h00);
    @(negedge clk_sys);
    dat = regRdata;
  endtask
endmodule // crs_host_model

// >>> sim/crs_props.sv
// Purpose: Checker for the scheduler. Assumes: one clock. Notes: timed starts are bounded below.
`timescale 1ns/1ps
module crs_props #(parameter TEMP_CYCLES = 1500000, VOLT_CYCLES = 284000, UNIT_CYCLES = 18200000) (
  input wire clk_sys, input wire resetn, input wire [7:0] regAddr, input wire regWrite, input wire regRead,
  input wire [7:0] regWdata, input wire [7:0] regRdata, input wire low_power_select, input wire attentionEnable,
  input wire [4:0] voltageSensorEnable, input wire scanStart, input wire scanDone, input wire attentionRequest,
  input wire [1:0] rateSelect);
  localparam int SLO = 3 * TEMP_CYCLES + 5 * VOLT_CYCLES;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  reg  [31:0] since;
  wire [4:0]  mult = (rateSelect == 2'h0) ? {4'h0, low_power_select} :
                     ((low_power_select ? 5'h4 : 5'h1) << (rateSelect - 2'h1));
  always @(posedge clk_sys or negedge resetn)
    if (!resetn) since <= 32'hffffffff;
    else if (scanStart) since <= 32'h1;
    else if (since != 32'hffffffff) since <= since + 32'h1;
  sequence s_cont_done;
    scanDone && rateSelect == 2'h0 && !low_power_select;
  endsequence
  sequence s_rate_wr;
    regWrite && regAddr == 8'h20;
  endsequence
  chk_rst_rate: assert property ($rose(resetn) |-> rateSelect == 2'h2) else $error("rate reset");
  chk_rate_write: assert property (s_rate_wr |=> rateSelect == $past(regWdata[1:0]))
    else $error("rate write");
  chk_rsv_zero: assert property (regRdata[7:2] == 6'h0) else $error("reserved bits");
  chk_read_back: assert property (regRead && !regWrite && regAddr == 8'h20 |=>
    regRdata == {6'h0, $past(rateSelect)}) else $error("read back");
  chk_other_read: assert property (regRead && regAddr != 8'h20 |=> regRdata == 8'h0) else $error("other read");
  chk_attn_gate: assert property (attentionRequest |->
    scanDone && attentionEnable && (|voltageSensorEnable)) else $error("attention gate");
  chk_attn_pulse: assert property (scanDone && attentionEnable && (|voltageSensorEnable)
    |-> attentionRequest) else $error("attention pulse");
  chk_scan_len: assert property ((since == SLO) == scanDone) else $error("scan length");
  chk_cont_restart: assert property (s_cont_done |-> ##2 scanStart) else $error("continuous");
  chk_timed_gap: assert property (scanStart |-> since >= mult * UNIT_CYCLES) else $error("interval");
endmodule // crs_props
bind crs_scheduler crs_props #(.TEMP_CYCLES(TEMP_CYCLES), .VOLT_CYCLES(VOLT_CYCLES), .UNIT_CYCLES(UNIT_CYCLES))
  crs_props_i (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWdata(regWdata), .regRdata(regRdata), .low_power_select(low_power_select), .attentionEnable(attentionEnable),
  .voltageSensorEnable(voltageSensorEnable), .scanStart(scanStart), .scanDone(scanDone),
  .attentionRequest(attentionRequest), .rateSelect(rateSelect));

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the scheduler. Assumes: short counts. Notes: host model drives registers.
`timescale 1ns/1ps
module testbench;
  localparam int T = 10, V = 4, U = 100;
  reg        clk_sys = 0, resetn = 0, low_power_select = 0, attentionEnable = 0;
  reg  [4:0] voltageSensorEnable = 5'h0;
  reg  [7:0] d;
  wire [7:0] regAddr, regWdata, regRdata;
  wire       regWrite, regRead, convActive, convTemp, scanStart, scanDone, attentionRequest;
  wire [2:0] convChannel;
  wire [1:0] rateSelect;
  int        mismatches = 0, checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  crs_scheduler #(.TEMP_CYCLES(T), .VOLT_CYCLES(V), .UNIT_CYCLES(U)) crs_scheduler_i (.clk_sys(clk_sys),
    .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .low_power_select(low_power_select), .attentionEnable(attentionEnable),
    .voltageSensorEnable(voltageSensorEnable), .convActive(convActive), .convTemp(convTemp),
    .convChannel(convChannel), .scanStart(scanStart), .scanDone(scanDone), .attentionRequest(attentionRequest),
    .rateSelect(rateSelect));
  crs_host_model crs_host_model_i (.clk_sys(clk_sys), .regRdata(regRdata), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));
  task conclude;
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task wait_for(input bit done, output int n);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while ((done ? scanDone : scanStart) !== 1'b1 && n < 4000);
    if (n >= 4000)
    begin
      mismatches++;
      conclude;
    end
  endtask
  task t_reg;
    crs_host_model_i.rd(8'h20, d);
    check(d, 8'h02, "reset read");
    crs_host_model_i.wr(8'h20, 8'hff);
    crs_host_model_i.rd(8'h20, d);
    check(d, 8'h03, "reserved read");
    check(rateSelect, 2'h3, "rate field");
    crs_host_model_i.wr(8'h21, 8'h00);
    crs_host_model_i.rd(8'h21, d);
    check(d, 8'h00, "other read");
    check(rateSelect, 2'h3, "rate kept");
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    crs_host_model_i.rd(8'h20, d);
    check(d, 8'h02, "reset again read");
    check(rateSelect, 2'h2, "reset again field");
  endtask
  task t_rates;
    int n, m;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      low_power_select <= i[2];
      crs_host_model_i.wr(8'h20, {6'h0, i[1:0]});
      wait_for(0, n);
      wait_for(0, n);
      m = (i[1:0] == 2'h0) ? i[2] : ((i[2] ? 4 : 1) << (i[1:0] - 2'h1));
      if (m == 0) check(n, 3 * T + 5 * V + 2, "continuous gap");
      else check(n >= m * U && n <= m * U + 4, 1, "timed gap");
    end
  endtask
  task t_attn;
    int n;
    @(posedge clk_sys);
    low_power_select <= 1'b0;
    crs_host_model_i.wr(8'h20, 8'h00);
    for (int i = 1; i < 4; i++)
    begin
      @(posedge clk_sys);
      attentionEnable <= i[0];
      voltageSensorEnable <= {i[1], 4'h0};
      wait_for(1, n);
      check(attentionRequest, i == 3, "attention");
    end
  endtask
  task t_scan;
    int n;
    wait_for(0, n);
    for (int j = 0; j <= 3 * T + 5 * V; j++)
    begin
      check(scanStart, j == 0, "scan start");
      check(convActive, j < 3 * T + 5 * V, "scan active");
      check(convTemp, j < 3 * T, "temp phase");
      check(convChannel, (j < 3 * T) ? j / T : ((j < 3 * T + 5 * V) ? (j - 3 * T) / V : 0), "channel");
      check(scanDone, j == 3 * T + 5 * V, "scan done");
      @(negedge clk_sys);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reg;
    t_rates;
    t_attn;
    t_scan;
    conclude;
  end
endmodule // testbench
